// file: hw/rid_operand_decoder.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - nm fields 11:8, 7:4; MAC post-increments both
// - md load base 7:4, disp 3:0, index zero dest
// - nd4 store base 7:4, disp 3:0, index zero src
// - nmd fields 11:8, 7:4, disp 3:0
// - d format 8-bit displacement 7:0
// - d12 format 12-bit PC-relative displacement
// - nd8 dest 11:8, PC displacement 7:0
// - i format 8-bit immediate 7:0
// - ni dest 11:8, immediate 7:0
// - byte swap exchanges low two bytes
// - extract middle of concatenated registers
// - add with carry through test flag
// - add with signed overflow check
// - subtract with borrow through test flag
// - subtract with signed underflow check
// - signed and unsigned divide init, divide step
// - PC displacement sign-extended, doubled, added
// - 4-bit displacement zero-extended, scaled, added
// - global-base displacement zero-extended, scaled, added
// - immediates zero, sign, or trap times four
module rid_operand_decoder (
  // Clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            rstn_i,
  // Decode request
  input  wire logic            req_valid_i,
  input  wire rid_pkg::rid_req_type req_i,
  // Decoded result
  output logic                 res_valid_o,
  output rid_pkg::rid_res_type res_o
);
  import rid_pkg::*;

  function automatic logic [31:0] rid_scale(
    input logic [31:0] v,
    input rid_size_type sz
  );
    case (sz)
      SZ_WORD: return v << WORD_SH;
      SZ_LONG: return v << LONG_SH;
      default: return v;
    endcase
  endfunction : rid_scale

  function automatic logic [31:0] rid_pc_rel(
    input logic [31:0] pc,
    input logic [31:0] sdisp
  );
    return pc + (sdisp << PC_SH);
  endfunction : rid_pc_rel

  // Raw instruction fields
  logic [3:0]  fld_hi;
  logic [3:0]  fld_lo;
  logic [3:0]  disp4;
  logic [7:0]  disp8;
  logic [11:0] disp12;

  assign fld_hi = req_i.instr[RN_HI:RN_LO];
  assign fld_lo = req_i.instr[RM_HI:RM_LO];
  assign disp4  = req_i.instr[D4_HI:FLD_LO];
  assign disp8  = req_i.instr[D8_HI:FLD_LO];
  assign disp12 = req_i.instr[D12_HI:FLD_LO];

  // Format flags
  logic is_nm;
  logic is_md;
  logic is_nd4;
  logic is_nmd;
  logic is_d;
  logic is_d12;
  logic is_nd8;
  logic is_i;
  logic is_ni;

  assign is_nm  = req_i.fmt == FMT_NM;
  assign is_md  = req_i.fmt == FMT_MD;
  assign is_nd4 = req_i.fmt == FMT_ND4;
  assign is_nmd = req_i.fmt == FMT_NMD;
  assign is_d   = req_i.fmt == FMT_D;
  assign is_d12 = req_i.fmt == FMT_D12;
  assign is_nd8 = req_i.fmt == FMT_ND8;
  assign is_i   = req_i.fmt == FMT_I;
  assign is_ni  = req_i.fmt == FMT_NI;

  // Register fields
  logic [3:0] dest_fld;
  logic [3:0] src_fld;
  logic       dest_idx0;
  logic       src_idx0;
  logic       glob_store;

  assign glob_store = is_d && req_i.base_sel == BASE_GLOBAL && !req_i.is_load;

  assign dest_fld = (is_nm || is_nmd || is_nd8 || is_ni) ? fld_hi :
                    is_nd4 ? fld_lo :
                    4'h0;
  assign src_fld  = (is_nm || is_nmd || is_md) ? fld_lo :
                    4'h0;
  assign dest_idx0 = is_md ||
                     (is_d && !glob_store) ||
                     (is_i && req_i.base_sel != BASE_GLOBAL);
  assign src_idx0  = is_nd4 || glob_store;

  // Displacement field
  logic [11:0] disp_out;

  assign disp_out = (is_md || is_nd4 || is_nmd) ? 12'(disp4) :
                    (is_d || is_nd8) ? 12'(disp8) :
                    is_d12 ? disp12 :
                    12'h000;

  // Immediate extension
  logic [31:0] imm_zx;
  logic [31:0] imm_sx;
  logic [31:0] imm_out;
  logic        has_imm;

  assign has_imm = is_i || is_ni;
  assign imm_zx  = 32'(disp8);
  assign imm_sx  = 32'($signed(disp8));
  assign imm_out = !has_imm ? 32'h0000_0000 :
                   is_ni ? imm_sx :
                   req_i.imm_sel == IMM_SIGN ? imm_sx :
                   req_i.imm_sel == IMM_TRAP ?
                     (imm_zx << TRAP_SH) :
                   imm_zx;

  // Effective address
  logic [31:0] reg_base;
  logic [31:0] ea_reg;
  logic [31:0] ea_glob;
  logic [31:0] ea_pc8;
  logic [31:0] ea_pc12;
  logic [31:0] ea_glob_idx;
  logic [31:0] ea_out;

  assign reg_base = (is_nmd && !req_i.is_load) ? req_i.reg_hi_val :
                    req_i.reg_lo_val;
  assign ea_reg   = reg_base + rid_scale(32'(disp4), req_i.size);
  assign ea_glob  = req_i.global_base_register +
                    rid_scale(32'(disp8), req_i.size);
  assign ea_pc8   = rid_pc_rel(req_i.pc, 32'($signed(disp8)));
  assign ea_pc12  = rid_pc_rel(req_i.pc, 32'($signed(disp12)));
  assign ea_glob_idx = req_i.global_base_register +
                       req_i.index_register_zero;

  assign ea_out = (is_md || is_nd4 || is_nmd) ? ea_reg :
                  (is_d && req_i.base_sel == BASE_GLOBAL) ? ea_glob :
                  (is_d || is_nd8) ? ea_pc8 :
                  is_d12 ? ea_pc12 :
                  (is_i && req_i.base_sel == BASE_GLOBAL) ? ea_glob_idx :
                  32'h0000_0000;

  // Arithmetic operands
  logic [31:0] op_n;
  logic [31:0] op_m;
  logic        t_in;
  logic        use_cin;
  logic [32:0] sum33;
  logic [32:0] dif33;

  assign op_n    = req_i.reg_hi_val;
  assign op_m    = req_i.reg_lo_val;
  assign t_in    = req_i.test_flag;
  assign use_cin = req_i.op == OP_ADD_CARRY || req_i.op == OP_SUB_BORROW;
  assign sum33   = {1'b0, op_n} + {1'b0, op_m} +
                   {32'h0000_0000, use_cin & t_in};
  assign dif33   = {1'b0, op_n} - {1'b0, op_m} -
                   {32'h0000_0000, use_cin & t_in};

  // Signed overflow and underflow
  logic add_ovf;
  logic sub_unf;

  assign add_ovf = (op_n[MSB] == op_m[MSB]) &&
                   (sum33[MSB] != op_n[MSB]);
  assign sub_unf = (op_n[MSB] != op_m[MSB]) &&
                   (dif33[MSB] != op_n[MSB]);

  // Byte swap and extract
  logic [31:0] swap_res;
  logic [31:0] xtr_res;

  assign swap_res = {op_m[MSB:HALF], op_m[BYTE-1:0],
                     op_m[HALF-1:BYTE]};
  assign xtr_res  = {op_m[HALF-1:0], op_n[MSB:HALF]};

  // One divide step
  logic [31:0] div_shift;
  logic        div_sub;
  logic [32:0] div_r33;
  logic        div_q_new;
  logic        div_t_new;

  assign div_shift = {op_n[MSB-1:0], t_in};
  assign div_sub   = req_i.div_q == req_i.div_m;
  assign div_r33   = div_sub ? {1'b0, div_shift} - {1'b0, op_m} :
                               {1'b0, div_shift} + {1'b0, op_m};
  assign div_q_new = op_n[MSB] ^ req_i.div_m ^ div_r33[XLEN];
  assign div_t_new = div_q_new == req_i.div_m;

  // Multiply-accumulate
  logic [31:0] mac_prod;
  logic [63:0] mac_sum;

  assign mac_prod = {{HALF{req_i.mac_opnd_a[HALF-1]}}, req_i.mac_opnd_a} *
                    {{HALF{req_i.mac_opnd_b[HALF-1]}}, req_i.mac_opnd_b};
  assign mac_sum  = {req_i.mac_accum_high, req_i.mac_accum_low} +
                    64'($signed(mac_prod));

  // Operation result selection
  logic [31:0] alu_res;
  logic        alu_we;
  logic        t_out;
  logic        t_we;
  logic        m_out;
  logic        q_out;
  logic        ovf_out;
  logic        mac_we;

  always_comb begin
    alu_res = 32'h0000_0000;
    alu_we  = 1'b0;
    t_out   = t_in;
    t_we    = 1'b0;
    m_out   = req_i.div_m;
    q_out   = req_i.div_q;
    ovf_out = 1'b0;
    mac_we  = 1'b0;
    case (req_i.op)
      OP_SWAP_B: begin
        alu_res = swap_res;
        alu_we  = 1'b1;
      end
      OP_EXTRACT: begin
        alu_res = xtr_res;
        alu_we  = 1'b1;
      end
      OP_ADD_CARRY: begin
        alu_res = sum33[MSB:0];
        alu_we  = 1'b1;
        t_out   = sum33[XLEN];
        t_we    = 1'b1;
      end
      OP_ADD_OVF: begin
        alu_res = sum33[MSB:0];
        alu_we  = 1'b1;
        t_out   = add_ovf;
        t_we    = 1'b1;
        ovf_out = add_ovf;
      end
      OP_SUB_BORROW: begin
        alu_res = dif33[MSB:0];
        alu_we  = 1'b1;
        t_out   = dif33[XLEN];
        t_we    = 1'b1;
      end
      OP_SUB_UNF: begin
        alu_res = dif33[MSB:0];
        alu_we  = 1'b1;
        t_out   = sub_unf;
        t_we    = 1'b1;
        ovf_out = sub_unf;
      end
      OP_DIV_S0: begin
        m_out = op_m[MSB];
        q_out = op_n[MSB];
        t_out = op_m[MSB] ^ op_n[MSB];
        t_we  = 1'b1;
      end
      OP_DIV_U0: begin
        m_out = 1'b0;
        q_out = 1'b0;
        t_out = 1'b0;
        t_we  = 1'b1;
      end
      OP_DIV_STP: begin
        alu_res = div_r33[MSB:0];
        alu_we  = 1'b1;
        q_out   = div_q_new;
        t_out   = div_t_new;
        t_we    = 1'b1;
      end
      OP_MULTIPLY_ACCUMULATE_WORD_INSTR: begin
        mac_we = 1'b1;
      end
      OP_ADD_IMM: begin
        alu_res = op_n + imm_sx;
        alu_we  = 1'b1;
      end
      default: begin
        alu_we = 1'b0;
      end
    endcase
  end

  // Assemble next result
  rid_res_type res_d;
  rid_res_type res_q;
  logic        valid_q;

  always_comb begin
    res_d = '0;
    res_d.dest_register_field   = dest_fld;
    res_d.source_register_field = src_fld;
    res_d.dest_is_idx0          = dest_idx0;
    res_d.src_is_idx0           = src_idx0;
    res_d.disp                  = disp_out;
    res_d.imm                   = imm_out;
    res_d.eff_addr              = ea_out;
    res_d.alu_result            = alu_res;
    res_d.result_we             = alu_we;
    res_d.test_flag             = t_out;
    res_d.flag_we               = t_we;
    res_d.overflow              = ovf_out;
    res_d.div_m                 = m_out;
    res_d.div_q                 = q_out;
    res_d.mac_accum_high        = mac_sum[63:XLEN];
    res_d.mac_accum_low         = mac_sum[MSB:0];
    res_d.mac_we                = mac_we;
    res_d.src_ptr_next          = op_m + MAC_PTR_STEP;
    res_d.dest_ptr_next         = op_n + MAC_PTR_STEP;
  end

  // Output stage
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      res_q   <= '0;
      valid_q <= 1'b0;
    end else begin
      res_q   <= res_d;
      valid_q <= req_valid_i;
    end
  end

  assign res_o       = res_q;
  assign res_valid_o = valid_q;

endmodule : rid_operand_decoder

`default_nettype wire

// file: hw/rid_pkg.sv
package rid_pkg;

  // Widths
  localparam int XLEN = 32;
  localparam int ILEN = 16;

  // Instruction field positions
  localparam int RN_HI  = 11;
  localparam int RN_LO  = 8;
  localparam int RM_HI  = 7;
  localparam int RM_LO  = 4;
  localparam int D4_HI  = 3;
  localparam int D8_HI  = 7;
  localparam int D12_HI = 11;
  localparam int FLD_LO = 0;

  // Data field positions
  localparam int MSB    = 31;
  localparam int HALF   = 16;
  localparam int BYTE   = 8;

  // Scaling shifts and steps
  localparam int WORD_SH = 1;
  localparam int LONG_SH = 2;
  localparam int PC_SH   = 1;
  localparam int TRAP_SH = 2;
  localparam logic [31:0] MAC_PTR_STEP = 32'h0000_0002;

  typedef enum logic [3:0] {
    FMT_ZERO = 4'h0,
    FMT_NM   = 4'h1,
    FMT_MD   = 4'h2,
    FMT_ND4  = 4'h3,
    FMT_NMD  = 4'h4,
    FMT_D    = 4'h5,
    FMT_D12  = 4'h6,
    FMT_ND8  = 4'h7,
    FMT_I    = 4'h8,
    FMT_NI   = 4'h9
  } rid_fmt_type;

  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_SWAP_B  = 4'h1,
    OP_EXTRACT = 4'h2,
    OP_ADD_CARRY  = 4'h3,
    OP_ADD_OVF    = 4'h4,
    OP_SUB_BORROW = 4'h5,
    OP_SUB_UNF    = 4'h6,
    OP_DIV_S0  = 4'h7,
    OP_DIV_U0  = 4'h8,
    OP_DIV_STP = 4'h9,
    OP_MULTIPLY_ACCUMULATE_WORD_INSTR   = 4'ha,
    OP_ADD_IMM = 4'hb
  } rid_op_type;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } rid_size_type;

  typedef enum logic [1:0] {
    IMM_ZERO = 2'h0,
    IMM_SIGN = 2'h1,
    IMM_TRAP = 2'h2
  } rid_imm_type;

  typedef enum logic [1:0] {
    BASE_REG = 2'h0,
    BASE_GLOBAL = 2'h1,
    BASE_PC  = 2'h2
  } rid_base_type;

  typedef struct packed {
    logic [15:0]  instr;
    rid_fmt_type  fmt;
    rid_op_type   op;
    rid_size_type size;
    rid_imm_type  imm_sel;
    rid_base_type base_sel;
    logic         is_load;
    logic [31:0]  reg_hi_val;
    logic [31:0]  reg_lo_val;
    logic [31:0]  index_register_zero;
    logic [31:0]  global_base_register;
    logic [31:0]  pc;
    logic         test_flag;
    logic         div_m;
    logic         div_q;
    logic [31:0]  mac_accum_high;
    logic [31:0]  mac_accum_low;
    logic [15:0]  mac_opnd_a;
    logic [15:0]  mac_opnd_b;
  } rid_req_type;

  typedef struct packed {
    logic [3:0]  dest_register_field;
    logic [3:0]  source_register_field;
    logic        dest_is_idx0;
    logic        src_is_idx0;
    logic [11:0] disp;
    logic [31:0] imm;
    logic [31:0] eff_addr;
    logic [31:0] alu_result;
    logic        result_we;
    logic        test_flag;
    logic        flag_we;
    logic        overflow;
    logic        div_m;
    logic        div_q;
    logic [31:0] mac_accum_high;
    logic [31:0] mac_accum_low;
    logic        mac_we;
    logic [31:0] src_ptr_next;
    logic [31:0] dest_ptr_next;
  } rid_res_type;

endpackage : rid_pkg

// file: testbench/rid_operand_decoder_properties.sv
`timescale 1ns/10ps
`default_nettype none
module rid_operand_decoder_properties (
  // Clock and reset
  input wire logic                 clk_sys_i,
  input wire logic                 rstn_i,
  // Request and result
  input wire logic                 req_valid_i,
  input wire rid_pkg::rid_req_type req_i,
  input wire logic                 res_valid_o,
  input wire rid_pkg::rid_res_type res_o
);
  import rid_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  wire logic [15:0] ins  = req_i.instr;
  wire logic [31:0] n    = req_i.reg_hi_val;
  wire logic [31:0] m    = req_i.reg_lo_val;
  wire logic [32:0] ac   = {1'b0, n} + {1'b0, m} + 33'(req_i.test_flag);
  wire logic [31:0] pc12 = req_i.pc + {{19{ins[11]}}, ins[11:0], 1'b0};
  wire logic [31:0] md   = m + ({28'h0, ins[3:0]} << req_i.size);
  wire logic [31:0] ni   = {{24{ins[7]}}, ins[7:0]};

  property p_valid;
    $past(rstn_i) |-> res_valid_o == $past(req_valid_i);
  endproperty
  a_valid: assert property (p_valid) else $error("result valid lag wrong");

  property p_nm;
    $past(rstn_i) && $past(req_i.fmt) == FMT_NM |->
      res_o.dest_register_field == $past(ins[11:8]) &&
      res_o.source_register_field == $past(ins[7:4]);
  endproperty
  a_nm: assert property (p_nm) else $error("nm fields wrong");

  property p_md;
    $past(rstn_i) && $past(req_i.fmt) == FMT_MD |->
      res_o.eff_addr == $past(md) && res_o.dest_is_idx0;
  endproperty
  a_md: assert property (p_md) else $error("md address wrong");

  property p_d12;
    $past(rstn_i) && $past(req_i.fmt) == FMT_D12 |->
      res_o.eff_addr == $past(pc12) && res_o.disp == $past(ins[11:0]);
  endproperty
  a_d12: assert property (p_d12) else $error("d12 target wrong");

  property p_ni;
    $past(rstn_i) && $past(req_i.fmt) == FMT_NI |->
      res_o.imm == $past(ni) && res_o.dest_register_field == $past(ins[11:8]);
  endproperty
  a_ni: assert property (p_ni) else $error("ni immediate wrong");

  property p_add_carry;
    $past(rstn_i) && $past(req_i.op) == OP_ADD_CARRY |-> res_o.flag_we &&
      res_o.alu_result == $past(ac[31:0]) && res_o.test_flag == $past(ac[32]);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry add wrong");

  property p_swap;
    $past(rstn_i) && $past(req_i.op) == OP_SWAP_B |->
      res_o.alu_result == $past({m[31:16], m[7:0], m[15:8]});
  endproperty
  a_swap: assert property (p_swap) else $error("byte swap wrong");

  property p_xtr;
    $past(rstn_i) && $past(req_i.op) == OP_EXTRACT |->
      res_o.alu_result == $past({m[15:0], n[31:16]});
  endproperty
  a_xtr: assert property (p_xtr) else $error("extract wrong");

  property p_divu;
    $past(rstn_i) && $past(req_i.op) == OP_DIV_U0 |->
      !res_o.div_m && !res_o.div_q && !res_o.test_flag;
  endproperty
  a_divu: assert property (p_divu) else $error("divide init wrong");
endmodule : rid_operand_decoder_properties

bind rid_operand_decoder rid_operand_decoder_properties i_props (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
  .req_i(req_i), .res_valid_o(res_valid_o), .res_o(res_o));
`default_nettype wire

// file: testbench/rid_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module rid_fetch_model (
  // Clock
  input  wire logic                 clk_sys_i,
  // Next request from the bench
  input  wire logic                 go_i,
  input  wire rid_pkg::rid_req_type nxt_i,
  // Request towards the decoder
  output var  logic                 req_valid_o,
  output var  rid_pkg::rid_req_type req_o
);
  import rid_pkg::*;
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // Idle word toggles so stale fields never look valid
  always @(posedge clk_sys_i) begin
    #1;
    req_valid_o = go_i;
    req_o = go_i ? nxt_i : ~req_o;
  end
endmodule : rid_fetch_model
`default_nettype wire

// file: testbench/rid_operand_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rid_operand_decoder_bench;
  import rid_pkg::*;
  logic        clk_sys_i;
  logic        rstn_i;
  logic        go;
  rid_req_type nxt;
  logic        req_valid;
  rid_req_type req;
  logic        res_valid;
  rid_res_type res;
  rid_req_type q[$];
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic        rlast = 1'b0;
  logic [31:0] seed;

  rid_fetch_model i_fetch (.clk_sys_i(clk_sys_i), .go_i(go), .nxt_i(nxt),
    .req_valid_o(req_valid), .req_o(req));
  rid_operand_decoder i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .req_valid_i(req_valid), .req_i(req), .res_valid_o(res_valid),
    .res_o(res));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic check(input rid_req_type p);
    logic [31:0] n, m, s8, e;
    logic [15:0] i;
    logic        v;
    longint      t;
    n = p.reg_hi_val;
    m = p.reg_lo_val;
    i = p.instr;
    s8 = {{24{i[7]}}, i[7:0]};
    case (p.fmt)
      FMT_NM: begin
        chk(res.dest_register_field, i[11:8]);
        chk(res.source_register_field, i[7:4]);
      end
      FMT_MD: begin
        chk(res.source_register_field, i[7:4]);
        chk(res.dest_is_idx0, 1'b1);
        chk(res.eff_addr, m + (i[3:0] << p.size));
      end
      FMT_ND4: begin
        chk(res.dest_register_field, i[7:4]);
        chk(res.src_is_idx0, 1'b1);
        chk(res.eff_addr, m + (i[3:0] << p.size));
      end
      FMT_NMD: begin
        chk(res.dest_register_field, i[11:8]);
        chk(res.source_register_field, i[7:4]);
        chk(res.disp, i[3:0]);
        e = (p.is_load ? m : n) + (i[3:0] << p.size);
        chk(res.eff_addr, e);
      end
      FMT_D: begin
        chk(res.disp, i[7:0]);
        e = p.global_base_register + (i[7:0] << p.size);
        if (p.base_sel == BASE_PC) e = p.pc + (s8 << 1);
        chk(res.eff_addr, e);
        e = (p.base_sel == BASE_GLOBAL && !p.is_load) ? 32'h1 : 32'h2;
        chk({res.dest_is_idx0, res.src_is_idx0}, e);
      end
      FMT_D12: begin
        chk(res.disp, i[11:0]);
        chk(res.eff_addr, p.pc + {{19{i[11]}}, i[11:0], 1'b0});
      end
      FMT_ND8: begin
        chk(res.dest_register_field, i[11:8]);
        chk(res.eff_addr, p.pc + (s8 << 1));
      end
      FMT_I: begin
        e = p.imm_sel == IMM_SIGN ? s8 : {24'h0, i[7:0]};
        if (p.imm_sel == IMM_TRAP) e = {22'h0, i[7:0], 2'h0};
        chk(res.imm, e);
        e = p.global_base_register + p.index_register_zero;
        if (p.base_sel == BASE_GLOBAL)
          chk(res.eff_addr, e);
        else
          chk(res.dest_is_idx0, 1'b1);
      end
      FMT_NI: begin
        chk(res.dest_register_field, i[11:8]);
        chk(res.imm, s8);
      end
      default: ;
    endcase
    case (p.op)
      OP_SWAP_B: chk(res.alu_result, {m[31:16], m[7:0], m[15:8]});
      OP_EXTRACT: chk(res.alu_result, {m[15:0], n[31:16]});
      OP_ADD_CARRY, OP_SUB_BORROW: begin
        t = longint'(n) - m - p.test_flag;
        if (p.op == OP_ADD_CARRY) t = longint'(n) + m + p.test_flag;
        chk(res.alu_result, t[31:0]);
        chk(res.test_flag, t[32]);
      end
      OP_ADD_OVF, OP_SUB_UNF: begin
        e = p.op == OP_ADD_OVF ? n + m : n - m;
        v = ((n[31] == m[31]) == (p.op == OP_ADD_OVF)) && e[31] != n[31];
        chk(res.alu_result, e);
        chk(res.test_flag, v);
        chk(res.overflow, v);
      end
      OP_DIV_S0: chk({res.div_m, res.div_q, res.test_flag},
                     {m[31], n[31], m[31] ^ n[31]});
      OP_DIV_U0: chk({res.div_m, res.div_q, res.test_flag}, 3'h0);
      OP_DIV_STP: begin
        t = {n[30:0], p.test_flag} + longint'(m);
        if (p.div_q == p.div_m) t = {n[30:0], p.test_flag} - longint'(m);
        v = n[31] ^ p.div_m ^ t[32];
        chk(res.alu_result, t[31:0]);
        chk({res.div_q, res.test_flag}, {v, v == p.div_m});
      end
      OP_MULTIPLY_ACCUMULATE_WORD_INSTR: begin
        t = longint'($signed(p.mac_opnd_a));
        t = t * longint'($signed(p.mac_opnd_b));
        t = t + {p.mac_accum_high, p.mac_accum_low};
        chk(res.mac_accum_high, t[63:32]);
        chk(res.mac_accum_low, t[31:0]);
        chk({res.mac_we, res.result_we}, 2'h2);
        chk(res.src_ptr_next, m + 2);
        chk(res.dest_ptr_next, n + 2);
      end
      OP_ADD_IMM: chk(res.alu_result, n + s8);
      default: ;
    endcase
  endtask : check

  // Results are compared a half cycle after they land
  always @(negedge clk_sys_i) begin
    if (rlast === 1'b0) begin
      chk(res_valid, 1'b0);
      chk({31'h0, res === '0}, 32'h1);
    end else if (res_valid === 1'b1 && q.size() > 0) begin
      check(q.pop_front());
    end else begin
      chk({31'h0, res_valid}, 32'h0);
      chk(q.size(), 0);
    end
    if (rstn_i === 1'b1 && req_valid === 1'b1) q.push_back(req);
    rlast = rstn_i;
  end

  task automatic burst(input rid_fmt_type f, input rid_op_type o,
                       input int k);
    logic [319:0] w;
    rid_req_type  r;
    repeat (k) begin
      w = {xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs()};
      r = w[$bits(rid_req_type)-1:0];
      r.fmt = f;
      r.op = o;
      r.size = rid_size_type'(2'(xs() % 3));
      r.imm_sel = rid_imm_type'(2'(xs() % 3));
      r.base_sel = w[300] ? BASE_PC : BASE_GLOBAL;
      nxt = r;
      go = 1'b1;
      @(posedge clk_sys_i);
    end
    go = 1'b0;
    @(posedge clk_sys_i);
  endtask : burst

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      $display("[ERR] %0t run did not finish", $time);
      conclude();
    end
  end

  initial begin
    rstn_i = 1'b0;
    go = 1'b0;
    nxt = '0;
    seed = 32'hdaa6_4b2d;
    repeat (2) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    for (int k = 1; k < 10; k++) burst(rid_fmt_type'(k), OP_NONE, 40);
    $display("test formats done");
    for (int k = 1; k < 12; k++)
      burst(k == 11 ? FMT_NI : FMT_NM, rid_op_type'(k), 40);
    $display("test operations done");
    burst(FMT_D, OP_NONE, 3);
    repeat (3) @(posedge clk_sys_i);
    fork
      burst(FMT_NM, OP_ADD_CARRY, 6);
      begin
        repeat (3) @(posedge clk_sys_i);
        #1 rstn_i = 1'b0;
        @(posedge clk_sys_i);
        #1 rstn_i = 1'b1;
      end
    join
    repeat (3) @(posedge clk_sys_i);
    $display("test gap and reset done");
    conclude();
  end
endmodule : rid_operand_decoder_bench
`default_nettype wire
